// ==== rtl/baud_gen.sv ====
// Baud generator: divides the system clock into the 16x baud clock and its tick.
module baud_gen #(
  parameter int DIV_W = 7
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Programmed divide ratio, zero acts as one
  input wire logic [DIV_W-1:0] divisor,
  // One-cycle pulse at each falling edge of the baud clock
  output logic tick,
  output logic baud_clk
);

  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;
  logic [DIV_W-1:0] div_eff;

  // A divide ratio of one gives a tick on every clock cycle.
  // A count left above a newly lowered ratio wraps at once rather than running round.
  always_comb begin
    div_eff = (divisor == '0) ? DIV_W'(1) : divisor;
    tick = (cnt_q >= DIV_W'(div_eff - DIV_W'(1)));
    cnt_d = tick ? '0 : DIV_W'(cnt_q + DIV_W'(1));
  end

  // Counter and clock level; the level falls in the cycle the tick fires.
  // At divide by one the level cannot toggle at clock rate and stays high.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      baud_clk <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      baud_clk <= (cnt_d >= (div_eff >> 1));
    end
  end

  AST_DIV_ONE_TICK: assert property (@(posedge clk) disable iff (!rst_n)
      (divisor <= DIV_W'(1)) |-> tick) else $error("Tick missing at divide by one.");

  // tick spacing
  // A ratio rewritten just after the tick may legally tick early.
  AST_TICK_SPACING: assert property (@(posedge clk) disable iff (!rst_n)
      (tick && divisor == $past(divisor) && divisor == DIV_W'(3)) |=>
      (!tick || divisor != DIV_W'(3)) ##1 (!tick || divisor != DIV_W'(3)))
    else $error("Baud ticks closer than the divide ratio.");

endmodule

// ==== rtl/sync2.sv ====
// Two-flop synchroniser for signals that arrive from outside the clock domain.
module sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  // The first stage feeds only the second stage, never any logic.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

// ==== rtl/uart_pkg.sv ====
// Shared constants, field layouts and types of the UART transmit/receive timing block.
package uart_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_BAUD = 8'h0c;
  localparam logic [7:0] OFS_MASK = 8'h10;

  // Bit positions inside the status register.
  localparam int unsigned ST_OVR = 0;
  localparam int unsigned ST_FRM = 1;
  localparam int unsigned ST_PAR = 2;
  localparam int unsigned ST_BRK = 3;
  localparam int unsigned ST_MODEM = 4;
  localparam int unsigned ST_TC = 5;
  localparam int unsigned ST_TX_BUFFER_EMPTY_FLAG = 6;
  localparam int unsigned ST_RDY = 7;

  // Sequencing points, each the index (from zero) of the baud clock or bit it names.
  localparam logic [2:0] ARM_EMPTY_IDX = 3'h3;
  localparam logic [2:0] ARM_START_IDX = 3'h4;
  localparam logic [3:0] TK_SAMPLE_IDX = 4'h7;
  localparam logic [3:0] TK_FLAG_IDX = 4'ha;
  localparam logic [3:0] TK_LATCH_IDX = 4'hb;
  localparam logic [3:0] TK_MOVE_IDX = 4'he;
  localparam logic [3:0] TK_LAST_IDX = 4'hf;
  localparam logic [3:0] LAST_BIT_PAR = 4'ha;
  localparam logic [3:0] LAST_BIT_NOPAR = 4'h9;

  // Control register layout, most significant field first.
  typedef struct packed {
    logic dtr;
    logic rts;
    logic parity_en;
    logic modem_irq_enable;
    logic irq_global_enable;
  } ctrl_t;

  // Baud select register layout.
  typedef struct packed {
    logic clk_out_sel;
    logic [6:0] divisor;
  } baud_sel_t;

  // Pins that arrive from outside the clock domain.
  typedef struct packed {
    logic serial_in;
    logic cts_n;
    logic dsr_n;
    logic osc_input;
  } pins_t;

  // Reset values.
  localparam ctrl_t CTRL_RST = 5'h00;
  localparam baud_sel_t BAUD_RST = 8'h01;
  localparam logic [5:0] MASK_RST = 6'h3f;
  localparam pins_t PINS_RST = 4'he;

  typedef enum logic [1:0] {
    TX_IDLE = 2'h0,
    TX_ARM = 2'h1,
    TX_SHIFT = 2'h3
  } tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'h0,
    RX_START = 2'h1,
    RX_DATA = 2'h3,
    RX_STOP = 2'h2
  } rx_state_t;

endpackage

// ==== rtl/uart_tx_rx_flag_timing.sv ====
// UART transmit/receive sequencing, flags, interrupt and APB register file.
// Function
// - Clock out: input clock or 16x clock
// - Sequencing counted in 16x baud clocks
// - Empty shifter: output starts fifth tick
// - Busy: next character after 16th stop tick
// - Empty shifter: buffer empty at fourth tick
// - Busy: buffer empty at 15th stop tick
// - Status bit six follows buffer empty
// - CTS high withholds; release counts four/five
// - Transmit complete at 11th stop tick
// - Receive error flags at 11th tick
// - Data ready at 11th tick, bit seven
// - CTS/DSR change sets modem flag
// - RTS/DTR update on control write
// - Divide by one: 16x clock output stays high
//
// Design decisions made here: the APB slave port and the register offsets.
module uart_tx_rx_flag_timing
  import uart_pkg::*;
(
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial line and modem pins
  input wire logic serial_in,
  output logic serial_out,
  input wire logic cts_n,
  input wire logic dsr_n,
  output logic rts_n,
  output logic dtr_n,
  // Oscillator input and clock output
  input wire logic osc_input,
  output logic clock_out_pin,
  // Interrupt
  output logic irq_out
);

  pins_t pins_raw;
  pins_t pins_s;
  logic tick;
  logic baud_clk;
  logic cts_ok;
  logic access, wr_done, rd_done, addr_ok;
  logic tx_wr, rx_rd, st_wr, ctrl_wr;
  logic pready_q, pslverr_q, serial_out_q, rts_n_q, dtr_n_q, clk_out_q, irq_out_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_mux;
  ctrl_t ctrl_q;
  baud_sel_t baud_q;
  logic [5:0] mask_q;
  logic [5:0] stat_q;
  logic [5:0] ev;
  logic [5:0] clr;
  logic [1:0] modem_prev_q;
  logic modem_chg;
  tx_state_t tx_state_q;
  logic [7:0] hold_q;
  logic hold_full_q, chain_q, tx_last, tx_move, tc_set;
  logic [2:0] arm_cnt_q;
  logic [3:0] tx_tk_q, tx_idx_q;
  logic [10:0] shift_q;
  rx_state_t rx_state_q;
  logic [3:0] rx_tk_q, rx_idx_q;
  logic [8:0] rx_sh_q;
  logic stop_ok_q, rx_done, rx_ready_q;
  logic [7:0] rx_buf_q;
  logic [7:0] rx_data;
  logic [3:0] rx_err;
  logic irq_d;

  // Builds a frame, start bit first: start, data, even parity if enabled, stop.
  function automatic logic [10:0] make_frame(input logic [7:0] d, input logic pe);
    make_frame = pe ? {1'b1, ^d, d, 1'b0} : {2'h3, d, 1'b0};
  endfunction

  // Every pin from outside passes two flops before the logic sees it.
  assign pins_raw = '{serial_in: serial_in, cts_n: cts_n, dsr_n: dsr_n, osc_input: osc_input};
  sync2 #(.WIDTH($bits(pins_t)), .RST_VAL(PINS_RST)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(pins_raw),
    .q(pins_s)
  );

  baud_gen #(.DIV_W(7)) u_baud (
    .clk(pclk),
    .rst_n(presetn),
    .divisor(baud_q.divisor),
    .tick(tick),
    .baud_clk(baud_clk)
  );

  assign cts_ok = !pins_s.cts_n;

  // Ports are driven straight from their flops.
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign serial_out = serial_out_q;
  assign rts_n = rts_n_q;
  assign dtr_n = dtr_n_q;
  assign clock_out_pin = clk_out_q;
  assign irq_out = irq_out_q;

  // Bus decode; every access takes one wait state, so side effects land on one edge.
  always_comb begin
    access = psel && penable;
    wr_done = access && pready_q && pwrite;
    rd_done = access && pready_q && !pwrite;
    addr_ok = (paddr == OFS_DATA) || (paddr == OFS_STATUS) || (paddr == OFS_CTRL) ||
              (paddr == OFS_BAUD) || (paddr == OFS_MASK);
    tx_wr = wr_done && (paddr == OFS_DATA);
    rx_rd = rd_done && (paddr == OFS_DATA);
    st_wr = wr_done && (paddr == OFS_STATUS);
    ctrl_wr = wr_done && (paddr == OFS_CTRL);
  end

  // Read data; status bits six and seven show the live buffer levels.
  // live status bits
  always_comb begin
    unique case (paddr)
      OFS_DATA: rd_mux = {24'h000000, rx_buf_q};
      OFS_STATUS: rd_mux = {24'h000000, rx_ready_q, !hold_full_q, stat_q};
      OFS_CTRL: rd_mux = {27'h0, ctrl_q};
      OFS_BAUD: rd_mux = {24'h000000, baud_q};
      OFS_MASK: rd_mux = {26'h0, mask_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // APB answer: data and error are captured in the wait cycle and held to the end.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= access && !pready_q;
      if (access && !pready_q) begin
        prdata_q <= pwrite ? 32'h00000000 : rd_mux;
        pslverr_q <= !addr_ok;
      end
    end
  end

  // Configuration registers; modem outputs move on the completing write edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      baud_q <= BAUD_RST;
      mask_q <= MASK_RST;
      rts_n_q <= 1'b1;
      dtr_n_q <= 1'b1;
    end else begin
      if (ctrl_wr) begin
        ctrl_q <= ctrl_t'(pwdata[4:0]);
        rts_n_q <= !pwdata[3];
        dtr_n_q <= !pwdata[4];
      end
      if (wr_done && paddr == OFS_BAUD) baud_q <= baud_sel_t'(pwdata[7:0]);
      if (wr_done && paddr == OFS_MASK) mask_q <= pwdata[5:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) clk_out_q <= 1'b0;
    else clk_out_q <= baud_q.clk_out_sel ? baud_clk : pins_s.osc_input;
  end

  assign tx_last = (tx_idx_q == (ctrl_q.parity_en ? LAST_BIT_PAR : LAST_BIT_NOPAR));

  // Holding buffer moves into the shifter on the fourth tick when idle, or on the
  // 15th tick of the last stop bit when a character is chained.
  always_comb begin
    tx_move = (tx_state_q == TX_ARM && tick && arm_cnt_q == ARM_EMPTY_IDX) ||
              (tx_state_q == TX_SHIFT && tick && tx_last && tx_tk_q == TK_MOVE_IDX && chain_q);
    tc_set = tx_state_q == TX_SHIFT && tick && tx_last && tx_tk_q == TK_FLAG_IDX && !hold_full_q;
  end

  // Holding buffer; a write in the cycle of a move wins and keeps the buffer full.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= 8'h00;
      hold_full_q <= 1'b0;
    end else begin
      if (tx_move) hold_full_q <= 1'b0;
      if (tx_wr) begin
        hold_q <= pwdata[7:0];
        hold_full_q <= 1'b1;
      end
    end
  end

  // Transmit sequencer. CTS is checked only when leaving idle and at the 12th
  // tick of the last stop bit, so a frame already started always completes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_q <= TX_IDLE;
      arm_cnt_q <= 3'h0;
      tx_tk_q <= 4'h0;
      tx_idx_q <= 4'h0;
      shift_q <= 11'h7ff;
      chain_q <= 1'b0;
      serial_out_q <= 1'b1;
    end else begin
      unique case (tx_state_q)
        TX_IDLE: begin
          arm_cnt_q <= 3'h0;
          if (hold_full_q && cts_ok) tx_state_q <= TX_ARM;
        end
        TX_ARM: begin
          if (tick) begin
            arm_cnt_q <= 3'(arm_cnt_q + 3'h1);
            if (arm_cnt_q == ARM_EMPTY_IDX) shift_q <= make_frame(hold_q, ctrl_q.parity_en);
            if (arm_cnt_q == ARM_START_IDX) begin
              serial_out_q <= shift_q[0];
              tx_tk_q <= 4'h0;
              tx_idx_q <= 4'h0;
              chain_q <= 1'b0;
              tx_state_q <= TX_SHIFT;
            end
          end
        end
        TX_SHIFT: begin
          if (tick) begin
            tx_tk_q <= 4'(tx_tk_q + 4'h1);
            if (tx_last && tx_tk_q == TK_LATCH_IDX) chain_q <= hold_full_q && cts_ok;
            if (tx_last && tx_tk_q == TK_MOVE_IDX && chain_q) begin
              shift_q <= make_frame(hold_q, ctrl_q.parity_en);
            end
            if (tx_tk_q == TK_LAST_IDX) begin
              if (!tx_last) begin
                serial_out_q <= shift_q[1];
                shift_q <= {1'b1, shift_q[10:1]};
                tx_idx_q <= 4'(tx_idx_q + 4'h1);
              end else if (chain_q) begin
                serial_out_q <= shift_q[0];
                tx_idx_q <= 4'h0;
                chain_q <= 1'b0;
              end else begin
                tx_state_q <= TX_IDLE;
              end
            end
          end
        end
        default: tx_state_q <= TX_IDLE;
      endcase
    end
  end

  // Receive data and error decode from the shifted bits.
  always_comb begin
    rx_data = ctrl_q.parity_en ? rx_sh_q[7:0] : rx_sh_q[8:1];
    rx_done = rx_state_q == RX_STOP && tick && rx_tk_q == TK_FLAG_IDX;
    rx_err[ST_OVR] = rx_ready_q;
    rx_err[ST_FRM] = !stop_ok_q;
    rx_err[ST_PAR] = ctrl_q.parity_en && (^rx_sh_q);
    rx_err[ST_BRK] = !stop_ok_q && (rx_data == 8'h00) && !(ctrl_q.parity_en && rx_sh_q[8]);
  end

  // Receive sequencer; bits are sampled at mid-bit, flags land at the 11th stop tick.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_q <= RX_IDLE;
      rx_tk_q <= 4'h0;
      rx_idx_q <= 4'h0;
      rx_sh_q <= 9'h000;
      stop_ok_q <= 1'b1;
    end else begin
      unique case (rx_state_q)
        RX_IDLE: begin
          rx_tk_q <= 4'h0;
          if (tick && !pins_s.serial_in) rx_state_q <= RX_START;
        end
        RX_START: begin
          if (tick) begin
            rx_tk_q <= 4'(rx_tk_q + 4'h1);
            // A start bit that is high again at mid-bit was a glitch.
            if (rx_tk_q == TK_SAMPLE_IDX && pins_s.serial_in) rx_state_q <= RX_IDLE;
            else if (rx_tk_q == TK_LAST_IDX) begin
              rx_idx_q <= 4'h0;
              rx_state_q <= RX_DATA;
            end
          end
        end
        RX_DATA: begin
          if (tick) begin
            rx_tk_q <= 4'(rx_tk_q + 4'h1);
            if (rx_tk_q == TK_SAMPLE_IDX) rx_sh_q <= {pins_s.serial_in, rx_sh_q[8:1]};
            if (rx_tk_q == TK_LAST_IDX) begin
              rx_idx_q <= 4'(rx_idx_q + 4'h1);
              if (rx_idx_q == (ctrl_q.parity_en ? 4'h8 : 4'h7)) rx_state_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (tick) begin
            rx_tk_q <= 4'(rx_tk_q + 4'h1);
            if (rx_tk_q == TK_SAMPLE_IDX) stop_ok_q <= pins_s.serial_in;
            if (rx_tk_q == TK_FLAG_IDX) rx_state_q <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // Receive buffer and data-ready flag; a new character wins over a read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buf_q <= 8'h00;
      rx_ready_q <= 1'b0;
    end else begin
      if (rx_rd) rx_ready_q <= 1'b0;
      if (rx_done) begin
        rx_buf_q <= rx_data;
        rx_ready_q <= 1'b1;
      end
    end
  end

  // Modem input change detect on the synchronised levels.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) modem_prev_q <= 2'h3;
    else modem_prev_q <= {pins_s.cts_n, pins_s.dsr_n};
  end
  assign modem_chg = (modem_prev_q != {pins_s.cts_n, pins_s.dsr_n});

  // Sticky event bits; they set regardless of enables and clear on write-one.
  // Reading the receive buffer also clears the receive errors so the line drops.
  always_comb begin
    ev = {tc_set, modem_chg, rx_done ? rx_err : 4'h0};
    clr = (st_wr ? pwdata[5:0] : 6'h00) | (rx_rd ? 6'h0f : 6'h00);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) stat_q <= 6'h00;
    else stat_q <= (stat_q & ~clr) | ev;
  end

  always_comb begin
    irq_d = ctrl_q.irq_global_enable &&
            ((|(stat_q[ST_BRK:ST_OVR] & mask_q[ST_BRK:ST_OVR])) ||
             (stat_q[ST_TC] && mask_q[ST_TC]) ||
             (stat_q[ST_MODEM] && mask_q[ST_MODEM] && ctrl_q.modem_irq_enable));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) irq_out_q <= 1'b0;
    else irq_out_q <= irq_d;
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_arm_tick(logic [2:0] idx);
    tx_state_q == TX_ARM && tick && arm_cnt_q == idx;
  endsequence

  sequence s_stop_tick(logic [3:0] idx);
    tx_state_q == TX_SHIFT && tick && tx_last && tx_tk_q == idx;
  endsequence

  AST_CLK_OUT_SEL: assert property (##1 clock_out_pin ==
      ($past(baud_q.clk_out_sel) ? $past(baud_clk) : $past(pins_s.osc_input)))
    else $error("Clock output source wrong.");
  AST_BIT_16_TICKS: assert property ((tx_state_q == TX_SHIFT && tick && !tx_last)
      |=> $changed(tx_idx_q) == ($past(tx_tk_q) == TK_LAST_IDX))
    else $error("Bit index moved off the 16th tick.");
  AST_START_FIFTH: assert property (s_arm_tick(ARM_START_IDX) |=>
      tx_state_q == TX_SHIFT && !serial_out)
    else $error("Start bit not driven on fifth tick.");
  AST_EMPTY_FOURTH: assert property ((s_arm_tick(ARM_EMPTY_IDX) ##0 !tx_wr) |=>
      !hold_full_q && serial_out)
    else $error("Buffer empty not on fourth tick.");
  AST_CHAIN_START: assert property ((s_stop_tick(TK_LAST_IDX) ##0 chain_q) |=>
      !serial_out && tx_idx_q == 4'h0)
    else $error("Chained character did not start.");
  AST_CHAIN_EMPTY: assert property ((s_stop_tick(TK_MOVE_IDX) ##0 chain_q && !tx_wr) |=>
      !hold_full_q)
    else $error("Buffer empty not on 15th stop tick.");
  AST_CTS_WITHHOLD: assert property ((tx_state_q == TX_IDLE && pins_s.cts_n) |=>
      tx_state_q == TX_IDLE)
    else $error("Transmit left idle with CTS high.");
  AST_STATUS_D6: assert property ((access && !pready_q && !pwrite && paddr == OFS_STATUS)
      |=> prdata[ST_TX_BUFFER_EMPTY_FLAG] == !$past(hold_full_q))
    else $error("Status bit six does not follow buffer empty.");
  AST_TC_SET: assert property ((s_stop_tick(TK_FLAG_IDX) ##0 !hold_full_q) |=>
      stat_q[ST_TC])
    else $error("Transmit complete not set.");
  AST_RX_FLAGS: assert property (rx_done |=> rx_ready_q &&
      stat_q[ST_FRM] == (!$past(stop_ok_q) || ($past(stat_q[ST_FRM]) && !$past(clr[ST_FRM]))) &&
      stat_q[ST_OVR] == ($past(rx_ready_q) || ($past(stat_q[ST_OVR]) && !$past(clr[ST_OVR]))))
    else $error("Receive flags not updated at 11th tick.");
  AST_RX_READY: assert property (rx_done |=> rx_ready_q ##0 (rx_buf_q == $past(rx_data)))
    else $error("Data ready or buffer wrong.");
  AST_MODEM_FLAG: assert property (modem_chg |=> stat_q[ST_MODEM] ##1
      (irq_out || !($past(ctrl_q.irq_global_enable) && $past(ctrl_q.modem_irq_enable) &&
      $past(mask_q[ST_MODEM]))))
    else $error("Modem change not flagged or signalled.");
  AST_RTS_DTR: assert property (ctrl_wr |=> rts_n == !$past(pwdata[3]) &&
      dtr_n == !$past(pwdata[4]))
    else $error("RTS or DTR not updated on control write.");
  AST_READ_CLEARS: assert property ((rx_rd && !rx_done) |=> !rx_ready_q)
    else $error("Buffer read did not clear data ready.");
  AST_IRQ_OFF: assert property (!ctrl_q.irq_global_enable |=> !irq_out)
    else $error("Interrupt raised while globally disabled.");

endmodule

// ==== tb/serial_peer.sv ====
// Serial line peer that sends framed characters into the receiver.
module serial_peer (
  // Clock
  input wire logic pclk,
  // Line into the receiver
  output logic serial_in
);
  timeunit 1ns;
  timeprecision 1ns;

  // The line idles high between frames.
  initial serial_in = 1'b1;

  // sixteen ticks per bit
  // Start, eight bits LSB first, then a stop bit that may be broken on purpose.
  task automatic send(input logic [7:0] d, input logic stp);
    logic [9:0] f;
    f = {stp, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      serial_in <= f[i];
      repeat (16) @(posedge pclk);
    end
    // One idle edge, so a following frame never reassigns the line in this step.
    serial_in <= 1'b1;
    @(posedge pclk);
  endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking testbench for the UART transmit/receive timing block.
module testbench
  import uart_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
  logic [7:0] paddr, b, b2, b3;
  logic [31:0] pwdata, prdata, rd;
  logic serial_in, serial_out, cts_n, dsr_n, rts_n, dtr_n;
  logic osc_input, clock_out_pin, irq_out;
  int err_count, n_checks, seed, n;

  uart_tx_rx_flag_timing u_uart_tx_rx_flag_timing (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_in(serial_in),
    .serial_out(serial_out), .cts_n(cts_n), .dsr_n(dsr_n), .rts_n(rts_n),
    .dtr_n(dtr_n), .osc_input(osc_input), .clock_out_pin(clock_out_pin),
    .irq_out(irq_out));
  serial_peer peer (.pclk(pclk), .serial_in(serial_in));

  // Clock of 100 ns period.
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Slow oscillator pin, so the buffered copy can be seen to move.
  initial begin
    osc_input = 1'b0;
    forever begin
      repeat (3) @(posedge pclk);
      osc_input <= ~osc_input;
    end
  end

  // Counts and reports one comparison.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready is seen high at an edge, then one idle
  // edge so that a following call never reassigns the bus in the same step.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Waits for a start bit, then samples each bit at its middle.
  task automatic grab(output logic [7:0] d, output int t);
    t = 0;
    while (serial_out !== 1'b0 && t < 400) begin
      @(posedge pclk);
      t++;
    end
    repeat (8) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge pclk);
      d[i] = serial_out;
    end
    repeat (16) @(posedge pclk);
    chk(serial_out, 1'b1); // stop bit
  endtask

  // Counts changes of the clock output over 24 cycles.
  task automatic edges(output int c);
    logic l;
    c = 0;
    l = clock_out_pin;
    repeat (24) begin
      @(posedge pclk);
      if (clock_out_pin !== l) c++;
      l = clock_out_pin;
    end
  endtask

  // Receives frames from the peer, then reads status and the byte.
  task automatic rx_case(input logic [7:0] d, input logic stp, input int nf,
                         input logic [7:0] es);
    repeat (nf) peer.send(d, stp);
    chk(irq_out, {31'h0, es[3:0] != 4'h0}); // error interrupt
    apb(1'b0, OFS_STATUS, 0);
    chk(rd, {24'h0, es}); // flags at eleventh tick
    apb(1'b0, OFS_DATA, 0);
    chk(rd, {24'h0, d}); // received byte
    apb(1'b0, OFS_STATUS, 0);
    chk(rd[7], 1'b0); // read clears ready
  endtask

  // Verdict and end of run.
  task automatic final_report;
    if (err_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Hangs are cut short well beyond the fewer than two thousand cycles needed.
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    final_report;
  end

  // Main sequence.
  initial begin
    seed = 32'h54ed;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    cts_n = 1'b0;
    dsr_n = 1'b1;
    err_count = 0;
    n_checks = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({rts_n, dtr_n, serial_out, irq_out}, 4'he); // idle pins
    apb(1'b0, OFS_MASK, 0);
    chk(rd, 32'h3f);
    apb(1'b0, 8'h14, 0);
    chk(se, 1'b1);
    chk(rd, 32'h0);
    edges(n);
    chk(n > 6, 1'b1); // buffered input clock
    apb(1'b1, OFS_BAUD, 32'h81);
    repeat (2) @(posedge pclk);
    edges(n);
    chk(n, 0); // divide by one
    apb(1'b1, OFS_BAUD, 32'h83);
    repeat (4) @(posedge pclk);
    edges(n);
    chk(n, 16); // two level changes per three cycles
    apb(1'b1, OFS_BAUD, 32'h81);
    b = 8'($random(seed));
    apb(1'b1, OFS_DATA, {24'h0, b});
    fork
      grab(b2, n);
      begin
        repeat (20) @(posedge pclk);
        apb(1'b1, OFS_DATA, {24'h0, ~b});
      end
    join
    chk(n, 5 + 1); // start on fifth tick
    chk(b2, b); // first frame
    grab(b3, n);
    chk(n, 8); // next start at stop end
    chk(b3, 8'(~b)); // chained character
    repeat (8) @(posedge pclk);
    apb(1'b0, OFS_STATUS, 0);
    chk(rd, 32'h70); // empty, modem change and complete
    apb(1'b1, OFS_CTRL, 32'h01);
    @(posedge pclk);
    chk(irq_out, 1'b1); // complete interrupt
    apb(1'b1, OFS_STATUS, 32'h20);
    @(posedge pclk);
    chk(irq_out, 1'b0); // modem needs its enable
    apb(1'b1, OFS_CTRL, 32'h1b);
    @(posedge pclk);
    chk({irq_out, rts_n, dtr_n}, 3'h4); // enable and pins
    apb(1'b1, OFS_STATUS, 32'h10);
    dsr_n <= 1'b0;
    repeat (6) @(posedge pclk);
    apb(1'b0, OFS_STATUS, 0);
    chk(rd[4], 1'b1); // dsr change
    // cts raised well before any frame could start
    cts_n <= 1'b1;
    repeat (4) @(posedge pclk);
    b = 8'($random(seed));
    apb(1'b1, OFS_DATA, {24'h0, b});
    repeat (40) @(posedge pclk);
    chk(serial_out, 1'b1); // withheld
    cts_n <= 1'b0;
    grab(b2, n);
    chk(n, 2 + 1 + 5 + 1); // start on fifth tick after release
    chk(b2, b); // sent after release
    repeat (16) @(posedge pclk);
    apb(1'b1, OFS_STATUS, 32'h3f);
    // Nonzero data, so a bad stop bit reads as framing and not as break.
    b = 8'($random(seed)) | 8'h01;
    rx_case(b, 1'b1, 1, 8'hc0); // read before next frame
    rx_case(b, 1'b1, 2, 8'hc1); // overrun
    rx_case(b, 1'b0, 1, 8'hc2); // framing
    rx_case(8'h00, 1'b0, 1, 8'hca); // break
    chk(irq_out, 1'b0); // read drops interrupt
    final_report;
  end
endmodule
